// File: testbench/match_listener.sv
`timescale 1ns/100ps

module match_listener (
	input  wire logic   hclk,    // Clock
	input  wire logic   hresetn, // Reset, active low
	input  wire logic   tick,    // Shift clock pulse
	output logic [15:0] seen     // Pulses taken
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seen <= 16'h0000;
		end else if (tick) begin
			seen <= seen + 16'h0001;
		end
	end
endmodule : match_listener

// File: testbench/period_timer_checker.sv
`timescale 1ns/100ps

module period_timer_checker (
	input  wire logic        hclk,            // Clock
	input  wire logic        hresetn,         // Reset, active low
	input  wire logic        device_reset,    // Sync reset
	input  wire logic        hsel,            // Select
	input  wire logic [31:0] haddr,           // Address
	input  wire logic [1:0]  htrans,          // Transfer type
	input  wire logic        hwrite,          // Write
	input  wire logic        hready,          // Ready
	input  wire logic [31:0] hrdata,          // Read data
	input  wire logic        timer_irq,       // Interrupt request
	input  wire logic        ssp_shift_tick,  // Match pulse
	input  wire logic        pwm_cycle_start, // PWM restart
	input  wire logic [7:0]  pwm_timebase     // Count value
);
	logic       wr_r;
	logic       rd_r;
	logic [7:0] adr_r;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// --------------------------------------------------------
	// Data phase tracking
	// --------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r  <= 1'b0;
			rd_r  <= 1'b0;
			adr_r <= 8'h00;
		end else begin
			wr_r  <= hsel && hready && htrans == timer_pkg::HTRANS_NONSEQ && hwrite;
			rd_r  <= hsel && hready && htrans == timer_pkg::HTRANS_NONSEQ && !hwrite;
			adr_r <= haddr[7:0];
		end
	end

	// --------------------------------------------------------
	// Properties
	// --------------------------------------------------------
	a_pulse_pair: assert property (p_pulse_pair) else $error("pulses differ");
	property p_pulse_pair; ssp_shift_tick == pwm_cycle_start; endproperty
	a_wrap_zero: assert property (p_wrap_zero) else $error("no wrap");
	property p_wrap_zero; ssp_shift_tick |-> pwm_timebase == 8'h00; endproperty
	a_gap: assert property (p_gap) else $error("pulses too close");
	property p_gap; ssp_shift_tick |=> !ssp_shift_tick [*3]; endproperty
	a_step: assert property (p_step) else $error("bad count step");
	property p_step;
		$changed(pwm_timebase) && !($past(wr_r) && $past(adr_r) == timer_pkg::ADDR_COUNT)
		|-> pwm_timebase == 8'h00 || pwm_timebase == $past(pwm_timebase) + 8'h01;
	endproperty
	a_flag_bits: assert property (p_flag_bits) else $error("flag bits");
	property p_flag_bits; rd_r && adr_r == timer_pkg::ADDR_FLAGS
		|-> (hrdata & 32'hffff_fffd) == 32'h0000_0000; endproperty
	a_irq_flag: assert property (p_irq_flag) else $error("irq w/o flag");
	property p_irq_flag; rd_r && adr_r == timer_pkg::ADDR_FLAGS && $past(timer_irq)
		&& !$past(device_reset) |-> hrdata[1]; endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits");
	property p_upper_zero; rd_r && adr_r != timer_pkg::ADDR_STATUS
		|-> hrdata[31:8] == 24'h00_0000; endproperty
	a_ctrl_keep: assert property (p_ctrl_keep) else $error("count moved");
	property p_ctrl_keep; $past(wr_r) && $past(adr_r) == timer_pkg::ADDR_CONTROL
		&& !$past(device_reset) |-> $stable(pwm_timebase); endproperty
	a_dev_reset: assert property (p_dev_reset) else $error("reset state");
	property p_dev_reset; device_reset
		|=> pwm_timebase == 8'h00 && !timer_irq && !ssp_shift_tick; endproperty
endmodule : period_timer_checker

bind period_timer_with_scalers period_timer_checker u_period_timer_checker (
	.hclk(hclk), .hresetn(hresetn), .device_reset(device_reset), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .timer_irq(timer_irq), .ssp_shift_tick(ssp_shift_tick),
	.pwm_cycle_start(pwm_cycle_start), .pwm_timebase(pwm_timebase)
);

// File: testbench/period_timer_with_scalers_tb_top.sv
`timescale 1ns/100ps

module period_timer_with_scalers_tb_top;
	logic        hclk;
	logic        hresetn;
	logic        device_reset;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        timer_irq;
	logic        ssp_shift_tick;
	logic        pwm_cycle_start;
	logic [7:0]  pwm_timebase;
	logic [15:0] seen;
	logic [31:0] rd;
	int          err_total;
	int          comparisons;
	int          cyc;
	int          n;

	period_timer_with_scalers u_period_timer_with_scalers (
		.hclk(hclk), .hresetn(hresetn), .device_reset(device_reset),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .timer_irq(timer_irq),
		.ssp_shift_tick(ssp_shift_tick), .pwm_cycle_start(pwm_cycle_start),
		.pwm_timebase(pwm_timebase));
	match_listener u_match_listener (.hclk(hclk), .hresetn(hresetn),
		.tick(ssp_shift_tick), .seen(seen));

	// --------------------------------------------------------
	// Clock and hang guard
	// --------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end

	task automatic close_out;
		if (err_total == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Master holds each phase until hready is sampled high
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge hclk);
		haddr  <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= timer_pkg::HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask : rdc

	// Cycles between two match pulses
	task automatic gap(input logic [6:0] c, input int e);
		bus(1'b1, timer_pkg::ADDR_CONTROL, {25'h0, c});
		@(negedge hclk);
		while (!ssp_shift_tick) @(negedge hclk);
		n = 0;
		do begin @(negedge hclk); n++; end while (!ssp_shift_tick);
		chk(32'(n), 32'(e));
	endtask : gap

	// --------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------
	initial begin
		{hresetn, device_reset, hwrite, htrans} = 5'h00;
		{haddr, hwdata, err_total, comparisons, cyc} = '0;
		hsel = 1'b1;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(timer_pkg::ADDR_COUNT, 32'h0000_0000);
		rdc(timer_pkg::ADDR_PERIOD, 32'h0000_00ff);
		rdc(timer_pkg::ADDR_FLAGS, 32'h0000_0000);
		rdc(8'h40, 32'h0000_0000);
		bus(1'b1, timer_pkg::ADDR_ENABLES, 32'h0000_00ff);
		rdc(timer_pkg::ADDR_ENABLES, 32'h0000_007f);
		bus(1'b1, timer_pkg::ADDR_PERIOD, 32'h0000_0002);
		rdc(timer_pkg::ADDR_PERIOD, 32'h0000_0002);
		for (int i = 0; i < 4; i++) begin
			gap(7'h04 | 7'(i), i == 0 ? 12 : i == 1 ? 48 : 192);
		end
		// Postscaler 1:3, armed while stopped so no pulse is missed
		bus(1'b1, timer_pkg::ADDR_CONTROL, 32'h0000_0010);
		bus(1'b1, timer_pkg::ADDR_FLAGS, 32'h0000_0000);
		n = 32'(seen);
		bus(1'b1, timer_pkg::ADDR_CONTROL, 32'h0000_0014);
		@(negedge hclk);
		while (!timer_irq) @(negedge hclk);
		@(negedge hclk);
		chk(32'(seen) - 32'(n), 32'h0000_0003);
		repeat (40) @(negedge hclk);
		chk(32'(timer_irq), 32'h0000_0001);
		bus(1'b1, timer_pkg::ADDR_ENABLES, 32'h0000_0000);
		@(negedge hclk);
		chk(32'(timer_irq), 32'h0000_0000);
		bus(1'b1, timer_pkg::ADDR_CONTROL, 32'h0000_0010);
		rdc(timer_pkg::ADDR_FLAGS, 32'h0000_0002);
		bus(1'b1, timer_pkg::ADDR_FLAGS, 32'h0000_0000);
		rdc(timer_pkg::ADDR_FLAGS, 32'h0000_0000);
		bus(1'b1, timer_pkg::ADDR_ENABLES, 32'h0000_0002);
		chk(32'(timer_irq), 32'h0000_0000);
		bus(1'b1, timer_pkg::ADDR_COUNT, 32'h0000_0055);
		repeat (40) @(posedge hclk);
		rdc(timer_pkg::ADDR_COUNT, 32'h0000_0055);
		chk(32'(pwm_timebase), 32'h0000_0055);
		bus(1'b1, timer_pkg::ADDR_CONTROL, 32'h0000_007d);
		rdc(timer_pkg::ADDR_COUNT, 32'h0000_0055);
		repeat (100) @(posedge hclk);
		bus(1'b0, timer_pkg::ADDR_COUNT, 32'h0000_0000);
		chk(32'(rd != 32'h0000_0055), 32'h0000_0001);
		bus(1'b1, timer_pkg::ADDR_PERIOD, 32'h0000_0000);
		// Count must sit at the period, else it runs the full 8-bit lap
		bus(1'b1, timer_pkg::ADDR_COUNT, 32'h0000_0000);
		for (int i = 0; i < 2; i++) begin
			repeat (40) @(posedge hclk);
			bus(1'b0, timer_pkg::ADDR_STATUS, 32'h0000_0000);
			chk(32'(rd[7:4] != 4'h0), 32'h0000_0001);
			bus(1'b1, i == 0 ? timer_pkg::ADDR_COUNT : timer_pkg::ADDR_CONTROL,
				i == 0 ? 32'h0000_0000 : 32'h0000_007d);
			bus(1'b0, timer_pkg::ADDR_STATUS, 32'h0000_0000);
			chk(rd & 32'h0000_01f0, 32'h0000_0100);
		end
		bus(1'b1, timer_pkg::ADDR_PERIOD, 32'h0000_0033);
		device_reset <= 1'b1;
		@(posedge hclk);
		device_reset <= 1'b0;
		rdc(timer_pkg::ADDR_PERIOD, 32'h0000_00ff);
		rdc(timer_pkg::ADDR_COUNT, 32'h0000_0000);
		rdc(timer_pkg::ADDR_STATUS, 32'h0000_0000);
		close_out();
	end
endmodule : period_timer_with_scalers_tb_top

// File: verilog/period_timer_with_scalers.sv
`timescale 1ns/100ps

module period_timer_with_scalers (
	input  wire logic        hclk,         // System clock, oscillator
	input  wire logic        hresetn,      // Async reset, active low
	input  wire logic        device_reset, // Watchdog/brown-out reset
	input  wire logic        hsel,         // Slave select
	input  wire logic [31:0] haddr,        // Address
	input  wire logic [1:0]  htrans,       // Transfer type
	input  wire logic        hwrite,       // Write strobe
	input  wire logic [2:0]  hsize,        // Transfer size
	input  wire logic [31:0] hwdata,       // Write data
	input  wire logic        hready,       // Bus ready in
	output logic [31:0]      hrdata,       // Read data
	output logic             hreadyout,    // Slave ready
	output logic             hresp,        // Response
	output logic             timer_irq,    // Peripheral interrupt request
	output logic             ssp_shift_tick,// Match pulse to serial port
	output logic             pwm_cycle_start,// PWM period restart pulse
	output logic [7:0]       pwm_timebase  // PWM time base count
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] prescale_limit(input logic [1:0] sel);
		logic [3:0] lim;
		lim = timer_pkg::PRE_LIMIT_16;
		case (sel)
			timer_pkg::PRE_DIV1: begin
				lim = timer_pkg::PRE_LIMIT_1;
			end
			timer_pkg::PRE_DIV4: begin
				lim = timer_pkg::PRE_LIMIT_4;
			end
			default: begin
				lim = timer_pkg::PRE_LIMIT_16;
			end
		endcase
		return lim;
	endfunction : prescale_limit

	function automatic logic [31:0] widen8(input logic [7:0] v);
		return {24'h0000_00, v};
	endfunction : widen8

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	timer_pkg::bus_phase_s phase_r;
	timer_pkg::ctrl_s      ctrl_r;
	logic [7:0]            count_r;
	logic [7:0]            period_r;
	logic                  match_flag_r;
	logic [6:0]            enables_r;
	logic [1:0]            osc_div_r;
	logic [31:0]           rdata_nxt;
	logic                  ssp_tick_r;
	logic                  pwm_start_r;
	logic                  addr_take;
	logic                  wr_en;
	logic                  wr_count;
	logic                  wr_period;
	logic                  wr_control;
	logic                  wr_flags;
	logic                  wr_enables;
	logic                  osc_tick;
	logic                  pre_en;
	logic                  pre_done;
	logic                  timer_tick;
	logic                  at_period;
	logic                  match_evt;
	logic                  post_done;
	logic                  scaler_clr;
	logic [3:0]            pre_cnt;
	logic [3:0]            post_cnt;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	// Zero wait states; every access answers OKAY.
	assign hreadyout = 1'b1;
	assign hresp     = timer_pkg::HRESP_OKAY;

	assign addr_take = hsel && hready &&
		(htrans == timer_pkg::HTRANS_NONSEQ);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_r <= '0;
		end else if (hready) begin
			phase_r.pending <= addr_take;
			phase_r.write   <= hwrite;
			phase_r.addr    <= haddr[7:0];
		end
	end

	assign wr_en      = phase_r.pending && phase_r.write;
	assign wr_count   = wr_en && (phase_r.addr == timer_pkg::ADDR_COUNT);
	assign wr_period  = wr_en && (phase_r.addr == timer_pkg::ADDR_PERIOD);
	assign wr_control = wr_en &&
		(phase_r.addr == timer_pkg::ADDR_CONTROL);
	assign wr_flags   = wr_en && (phase_r.addr == timer_pkg::ADDR_FLAGS);
	assign wr_enables = wr_en &&
		(phase_r.addr == timer_pkg::ADDR_ENABLES);

	// Read value is snapped at the address phase, unmapped reads zero.
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (haddr[7:0])
			timer_pkg::ADDR_COUNT: begin
				rdata_nxt = widen8(count_r);
			end
			timer_pkg::ADDR_PERIOD: begin
				rdata_nxt = widen8(period_r);
			end
			timer_pkg::ADDR_CONTROL: begin
				rdata_nxt = widen8({1'b0, ctrl_r});
			end
			timer_pkg::ADDR_FLAGS: begin
				rdata_nxt[timer_pkg::FLAG_MATCH_BIT] = match_flag_r;
			end
			timer_pkg::ADDR_ENABLES: begin
				rdata_nxt = widen8({1'b0, enables_r});
			end
			timer_pkg::ADDR_STATUS: begin
				rdata_nxt[timer_pkg::STAT_PRE_LSB +: 4]  = pre_cnt;
				rdata_nxt[timer_pkg::STAT_POST_LSB +: 4] = post_cnt;
				rdata_nxt[timer_pkg::STAT_ON_BIT]        = ctrl_r.on;
			end
			default: begin
				rdata_nxt = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_take && !hwrite) begin
			hrdata <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Control and period registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= timer_pkg::RST_CONTROL;
		end else if (device_reset) begin
			ctrl_r <= timer_pkg::RST_CONTROL;
		end else if (wr_control) begin
			ctrl_r.pre  <= hwdata[timer_pkg::CTRL_PRE_MSB:
				timer_pkg::CTRL_PRE_LSB];
			ctrl_r.on   <= hwdata[timer_pkg::CTRL_ON_BIT];
			ctrl_r.post <= hwdata[timer_pkg::CTRL_POST_MSB:
				timer_pkg::CTRL_POST_LSB];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			period_r <= timer_pkg::RST_PERIOD;
		end else if (device_reset) begin
			period_r <= timer_pkg::RST_PERIOD;
		end else if (wr_period) begin
			period_r <= hwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Instruction clock and prescaler
	// ----------------------------------------------------------------
	// Free running so the instruction clock phase is independent of
	// the timer-on bit, as the core's own clock would be.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_div_r <= 2'b00;
		end else if (device_reset) begin
			osc_div_r <= 2'b00;
		end else if (osc_tick) begin
			osc_div_r <= 2'b00;
		end else begin
			osc_div_r <= osc_div_r + 2'b01;
		end
	end

	assign osc_tick   = (osc_div_r == timer_pkg::OSC_DIV_LAST);
	assign pre_en     = osc_tick && ctrl_r.on;
	assign scaler_clr = wr_count || wr_control || device_reset;

	scaler_counter u_prescaler (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clr     (scaler_clr),
		.en      (pre_en),
		.limit   (prescale_limit(ctrl_r.pre)),
		.cnt     (pre_cnt),
		.done    (pre_done)
	);

	// A clear in the same cycle masks the tick, so no count slips past.
	assign timer_tick = pre_done && !scaler_clr;

	// ----------------------------------------------------------------
	// Count register
	// ----------------------------------------------------------------
	assign at_period = (count_r == period_r);
	assign match_evt = timer_tick && at_period;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_r <= timer_pkg::RST_COUNT;
		end else if (device_reset) begin
			count_r <= timer_pkg::RST_COUNT;
		end else if (wr_count) begin
			count_r <= hwdata[7:0];
		end else if (match_evt) begin
			count_r <= timer_pkg::RST_COUNT;
		end else if (timer_tick) begin
			count_r <= count_r + 8'h01;
		end
		// Control writes fall through and keep the count.
	end

	// ----------------------------------------------------------------
	// Postscaler
	// ----------------------------------------------------------------
	scaler_counter u_postscaler (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clr     (scaler_clr),
		.en      (match_evt),
		.limit   (ctrl_r.post),
		.cnt     (post_cnt),
		.done    (post_done)
	);

	// ----------------------------------------------------------------
	// Flag and enable registers
	// ----------------------------------------------------------------
	// Hardware set beats a software clear in the same cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			match_flag_r <= 1'b0;
		end else if (device_reset) begin
			match_flag_r <= 1'b0;
		end else if (post_done) begin
			match_flag_r <= 1'b1;
		end else if (wr_flags) begin
			match_flag_r <= hwdata[timer_pkg::FLAG_MATCH_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enables_r <= timer_pkg::RST_ENABLES;
		end else if (device_reset) begin
			enables_r <= timer_pkg::RST_ENABLES;
		end else if (wr_enables) begin
			enables_r <= hwdata[timer_pkg::ENABLE_MSB:0];
		end
	end

	assign timer_irq = match_flag_r &&
		enables_r[timer_pkg::FLAG_MATCH_BIT];

	// ----------------------------------------------------------------
	// Consumer outputs
	// ----------------------------------------------------------------
	// Registered one cycle so the consumers see a clean pulse.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ssp_tick_r  <= 1'b0;
			pwm_start_r <= 1'b0;
		end else if (device_reset) begin
			ssp_tick_r  <= 1'b0;
			pwm_start_r <= 1'b0;
		end else begin
			ssp_tick_r  <= match_evt;
			pwm_start_r <= match_evt;
		end
	end

	assign ssp_shift_tick  = ssp_tick_r;
	assign pwm_cycle_start = pwm_start_r;
	assign pwm_timebase    = count_r;

endmodule : period_timer_with_scalers

// File: verilog/scaler_counter.sv
`timescale 1ns/100ps

module scaler_counter (
	input  wire logic       hclk,   // Clock
	input  wire logic       hresetn,// Async reset, active low
	input  wire logic       clr,    // Synchronous clear
	input  wire logic       en,     // Count enable
	input  wire logic [3:0] limit,  // Terminal count
	output logic [3:0]      cnt,    // Current count
	output logic            done    // Terminal count reached while enabled
);

	assign done = en && (cnt == limit);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= timer_pkg::RST_SCALER;
		end else if (clr || done) begin
			cnt <= timer_pkg::RST_SCALER;
		end else if (en) begin
			cnt <= cnt + 4'h1;
		end
	end

endmodule : scaler_counter

// File: verilog/timer_pkg.sv
package timer_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_FLAGS   = 8'h0c;
	localparam logic [7:0] ADDR_ENABLES = 8'h8c;
	localparam logic [7:0] ADDR_COUNT   = 8'h20;
	localparam logic [7:0] ADDR_PERIOD  = 8'h24;
	localparam logic [7:0] ADDR_CONTROL = 8'h28;
	localparam logic [7:0] ADDR_STATUS  = 8'h2c;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_PRE_LSB  = 0;
	localparam int CTRL_PRE_MSB  = 1;
	localparam int CTRL_ON_BIT   = 2;
	localparam int CTRL_POST_LSB = 3;
	localparam int CTRL_POST_MSB = 6;
	localparam int FLAG_MATCH_BIT = 1;
	localparam int ENABLE_MSB     = 6;
	localparam int STAT_PRE_LSB   = 0;
	localparam int STAT_POST_LSB  = 4;
	localparam int STAT_ON_BIT    = 8;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_COUNT   = 8'h00;
	localparam logic [7:0] RST_PERIOD  = 8'hff;
	localparam logic [6:0] RST_CONTROL = 7'h00;
	localparam logic [6:0] RST_ENABLES = 7'h00;
	localparam logic [3:0] RST_SCALER  = 4'h0;

	// ----------------------------------------------------------------
	// Timing counts
	// ----------------------------------------------------------------
	localparam int          OSC_DIV        = 4;
	localparam logic [1:0]  OSC_DIV_LAST   = 2'(OSC_DIV - 1);
	localparam logic [3:0]  PRE_LIMIT_1    = 4'h0;
	localparam logic [3:0]  PRE_LIMIT_4    = 4'h3;
	localparam logic [3:0]  PRE_LIMIT_16   = 4'hf;

	// ----------------------------------------------------------------
	// Bus encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic       HRESP_OKAY    = 1'b0;

	typedef enum logic [1:0] {
		PRE_DIV1  = 2'b00,
		PRE_DIV4  = 2'b01,
		PRE_DIV16 = 2'b10
	} prescale_e;

	typedef struct packed {
		logic [3:0] post;
		logic       on;
		logic [1:0] pre;
	} ctrl_s;

	typedef struct packed {
		logic       pending;
		logic       write;
		logic [7:0] addr;
	} bus_phase_s;

endpackage : timer_pkg
